/* File: lcd_chk_asserts.sv */
// checks on the lcd port pins
`timescale 1ns/1ps
module lcd_chk
  import lcd_pkg::*;
(
  // clock, reset, avalon
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  // host bus
  input wire logic PAR_SERIAL_SELECT_I,
  input wire logic CHIP_SELECT_LOW_B_I,
  input wire logic CHIP_SELECT_HIGH_I,
  input wire logic [7:0] DATA_OE_O,
  // timing pins and drive outputs
  input wire logic MASTER_SELECT_I,
  input wire logic INTERNAL_OSC_SELECT_I,
  input wire logic DOT_TIMING_PIN_OE_O,
  input wire logic ALTERNATION_SIGNAL_OE_O,
  input wire logic DISPLAY_OFF_SYNC_B_OE_O,
  input wire lvl_e [LINES-1:0] ROW_DRIVE_OUTPUTS_O,
  input wire lvl_e [COLS-1:0] COLUMN_DRIVE_OUTPUTS_O
);
  logic req;
  logic rows_ok;
  logic cols_ok;
  // request and legal drive levels
  assign req = AVS_READ_I || AVS_WRITE_I;
  always_comb begin
    rows_ok = 1'b1;
    cols_ok = 1'b1;
    for (int i = 0; i < LINES; i++)
      rows_ok &= ROW_DRIVE_OUTPUTS_O[i] inside
        {LVL_GND, LVL_V1, LVL_V2, LVL_V5};
    for (int i = 0; i < COLS; i++)
      cols_ok &= COLUMN_DRIVE_OUTPUTS_O[i] inside
        {LVL_GND, LVL_V1, LVL_V3, LVL_V4};
  end
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  a_wait_one_cycle: assert property (req && AVS_WAITREQUEST_O |=>
    !AVS_WAITREQUEST_O) else $error("wait too long");
  a_bus_all_bits: assert property (
    DATA_OE_O inside {8'h00, 8'hFF}) else $error("partial bus drive");
  a_desel_float: assert property (
    (CHIP_SELECT_LOW_B_I || !CHIP_SELECT_HIGH_I) [*8] |-> DATA_OE_O == 8'h00)
    else $error("bus driven deselected");
  a_serial_no_read: assert property (
    (!PAR_SERIAL_SELECT_I) [*8] |-> DATA_OE_O == 8'h00)
    else $error("bus driven in serial");
  a_osc_clock_out: assert property (
    (MASTER_SELECT_I && INTERNAL_OSC_SELECT_I) [*8] |-> DOT_TIMING_PIN_OE_O)
    else $error("clock pin not driven");
  a_master_drives: assert property (MASTER_SELECT_I [*8] |->
    ALTERNATION_SIGNAL_OE_O && DISPLAY_OFF_SYNC_B_OE_O)
    else $error("master pins not driven");
  a_slave_listens: assert property ((!MASTER_SELECT_I) [*8] |->
    !(ALTERNATION_SIGNAL_OE_O || DISPLAY_OFF_SYNC_B_OE_O ||
    DOT_TIMING_PIN_OE_O)) else $error("slave drives a pin");
  a_row_levels: assert property (rows_ok)
    else $error("bad row level");
  a_col_levels: assert property (cols_ok)
    else $error("bad column level");
  c_bus_accept: cover property (req && !AVS_WAITREQUEST_O);
  c_host_read: cover property (DATA_OE_O == 8'hFF);
  c_master_mode: cover property (ALTERNATION_SIGNAL_OE_O);
endmodule

/* File: lcd_host_port.sv */
// lcd driver host port, display ram and display timing
// Operation
// - row level from scan data and alternation; power saving gives ground
// - select pin high: parallel bus; low: serial on bit 7, clock bit 6
// - style pin high: enable plus read/write; low: separate low strobes
// - serial: 8-bit shift, 3-bit count, msb first, byte every eighth edge
// - data/command select sampled at every eighth edge; high means data
// - chip not selected: bus floats, strobes ignored, serial state reset
// - serial port is write only, nothing is read back
// - data writes go to a holder, committed to ram before next write
// - reads return data fetched by the previous read; dummy read needed
// - status read shows busy flag on bit 7
// - ram is 10 pages of 8 bits by 132 columns, byte access
// - page only changes by page set, never by data access
// - column steps after each data access, stops at 83h
// - swap bit reverses column to column output mapping
// - start line shown on top row, up to 80 rows follow
// - row position offset by start common before scan direction
// - invert and on/off act on latched data only, not on ram
// - duty picks 8 to 80 driven lines in steps of eight
// - display clock rate follows duty
// - internal oscillator only when master and osc select; else pin
// - master drives alternation and off sync; clock pin only with osc
// - line data latched on display clock, independent of host access
// - column level from ram bit and alternation; invert swaps pairs
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module lcd_host_port
  import lcd_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // avalon-mm register slave
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // host bus pins
  input wire logic PAR_SERIAL_SELECT_I,
  input wire logic BUS_STYLE_SELECT_I,
  input wire logic CHIP_SELECT_LOW_B_I,
  input wire logic CHIP_SELECT_HIGH_I,
  input wire logic DATA_COMMAND_SELECT_I,
  input wire logic RD_E_I,
  input wire logic WR_RW_I,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic [7:0] DATA_OE_O,
  // display timing pins
  input wire logic MASTER_SELECT_I,
  input wire logic INTERNAL_OSC_SELECT_I,
  input wire logic DOT_TIMING_PIN_I,
  output logic DOT_TIMING_PIN_O,
  output logic DOT_TIMING_PIN_OE_O,
  input wire logic ALTERNATION_SIGNAL_I,
  output logic ALTERNATION_SIGNAL_O,
  output logic ALTERNATION_SIGNAL_OE_O,
  input wire logic DISPLAY_OFF_SYNC_B_I,
  output logic DISPLAY_OFF_SYNC_B_O,
  output logic DISPLAY_OFF_SYNC_B_OE_O,
  // drive outputs
  output lvl_e [LINES-1:0] ROW_DRIVE_OUTPUTS_O,
  output lvl_e [COLS-1:0] COLUMN_DRIVE_OUTPUTS_O
);

  typedef enum logic {FILL_IDLE, FILL_RUN} fill_e;

  // flat ram index of a page and column
  function automatic logic [10:0] ram_idx(input logic [3:0] pg,
                                          input logic [7:0] col);
    ram_idx = 11'(int'(pg) * COLS + int'(col));
  endfunction

  // sum of two line numbers, wrapped into the 80 line range
  function automatic logic [6:0] wrap80(input logic [6:0] a,
                                        input logic [6:0] b);
    wrap80 = 7'((int'(a) + int'(b)) % LINES);
  endfunction

  // byte-enable merge of a register write
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (wd & m);
  endfunction

  logic [7:0] ram [RAM_WORDS];
  pins_s pin_raw, s1_r, s2_r, s3_r, pin_r, pin_q_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [6:0] start_line_r, start_com_r;
  logic [3:0] duty_r, page_r;
  logic [7:0] col_r, hold_r, sh_r, dout_r;
  logic [2:0] cnt_r;
  logic commit_r, resp_r, alt_r, dot_out_r;
  logic [31:0] rdata_r, div_r;
  logic [6:0] line_r, shown_row_r;
  logic [COLS-1:0] fill_buf_r, latch_r;
  logic [7:0] fcol_r;
  fill_e fill_r;
  lvl_e [LINES-1:0] row_nxt, row_r;
  lvl_e [COLS-1:0] colo_nxt, colo_r;

  // every pin passes four flip-flops
  assign pin_raw = {PAR_SERIAL_SELECT_I, BUS_STYLE_SELECT_I,
                    CHIP_SELECT_LOW_B_I, CHIP_SELECT_HIGH_I,
                    DATA_COMMAND_SELECT_I, RD_E_I, WR_RW_I, DATA_I,
                    MASTER_SELECT_I, INTERNAL_OSC_SELECT_I, DOT_TIMING_PIN_I,
                    ALTERNATION_SIGNAL_I, DISPLAY_OFF_SYNC_B_I};
  wire pins_s agree = ~(s2_r ^ s3_r);

  // synchroniser chain; a bit moves once stages two and three agree
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      s1_r <= PIN_IDLE;
      s2_r <= PIN_IDLE;
      s3_r <= PIN_IDLE;
      pin_r <= PIN_IDLE;
      pin_q_r <= PIN_IDLE;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (pin_r & ~agree) | (s3_r & agree);
      pin_q_r <= pin_r;
    end
  end

  // chip select, bus style and strobe decoding
  wire act_now = !pin_r.cs_low_b && pin_r.cs_high;
  wire active = act_now && !pin_q_r.cs_low_b && pin_q_r.cs_high;
  wire par = pin_r.par_sel;
  wire moto = pin_r.bus_style;
  wire rd_lvl = moto ? (pin_r.rd_e && pin_r.wr_rw) : !pin_r.rd_e;
  wire rd_lvl_q = moto ? (pin_q_r.rd_e && pin_q_r.wr_rw) : !pin_q_r.rd_e;
  wire wr_lvl = moto ? (pin_r.rd_e && !pin_r.wr_rw) : !pin_r.wr_rw;
  wire wr_lvl_q = moto ? (pin_q_r.rd_e && !pin_q_r.wr_rw) : !pin_q_r.wr_rw;
  wire par_wr = active && par && wr_lvl_q && !wr_lvl;
  wire par_rd_end = active && par && rd_lvl_q && !rd_lvl;

  // serial port: clock on bit 6, data on bit 7
  wire scl_rise = active && !par && pin_r.data[6] && !pin_q_r.data[6];
  wire [7:0] sh_nxt = {sh_r[6:0], pin_r.data[7]};
  wire ser_done = scl_rise && (cnt_r == 3'h7);

  // byte presented by either port
  wire wr_ev = par_wr || ser_done;
  wire [7:0] wr_byte = par ? pin_q_r.data : sh_nxt;
  wire wr_dc = par ? pin_q_r.dc : pin_r.dc;
  wire data_wr = wr_ev && wr_dc;
  wire cmd_wr = wr_ev && !wr_dc;
  wire [3:0] op = wr_byte[7:4];
  wire data_rd = par_rd_end && pin_q_r.dc;
  wire [7:0] col_inc = (col_r == COL_LAST) ? col_r : col_r + 8'h01;
  wire [7:0] col_hi = {wr_byte[3:0], col_r[3:0]};
  wire [7:0] col_lo = {col_r[7:4], wr_byte[3:0]};
  wire [7:0] status_byte = 8'({commit_r, 7'h00}) << (BUSY_BIT - 7);

  // serial shift register and bit counter, cleared while deselected
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || !act_now) begin
      sh_r <= 8'h00;
      cnt_r <= 3'h0;
    end else if (scl_rise) begin
      sh_r <= sh_nxt;
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // page and column addressing
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      page_r <= 4'h0;
      col_r <= 8'h00;
    end else begin
      if (cmd_wr && op == OP_PAGE && wr_byte[3:0] <= PAGE_LAST) begin
        page_r <= wr_byte[3:0];
      end
      if (cmd_wr && op == OP_COL_HI) begin
        col_r <= (col_hi > COL_LAST) ? COL_LAST : col_hi;
      end else if (cmd_wr && op == OP_COL_LO) begin
        col_r <= (col_lo > COL_LAST) ? COL_LAST : col_lo;
      end else if (commit_r || data_rd) begin
        col_r <= col_inc;
      end
    end
  end

  // bus holder: writes wait one cycle, reads fetch for the next read
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      hold_r <= 8'h00;
      commit_r <= 1'b0;
    end else begin
      commit_r <= data_wr;
      if (data_wr) begin
        hold_r <= wr_byte;
      end else if (data_rd) begin
        hold_r <= ram[ram_idx(page_r, col_r)];
      end
    end
  end

  // ram write port, committed from the holder
  always_ff @(posedge CLK_I) begin
    if (commit_r) begin
      ram[ram_idx(page_r, col_r)] <= hold_r;
    end
  end

  // parallel read data, floated unless a selected parallel read
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      dout_r <= 8'h00;
    end else begin
      dout_r <= pin_r.dc ? hold_r : status_byte;
    end
  end
  assign DATA_O = dout_r;
  assign DATA_OE_O = {8{active && par && rd_lvl}};

  // avalon slave: one wait cycle, then the answer
  wire req = AVS_READ_I || AVS_WRITE_I;
  wire wr_go = AVS_WRITE_I && resp_r;
  wire [31:0] ctrl_w = 32'(ctrl_r);
  wire [31:0] start_w = 32'(start_line_r) << START_LINE_LSB
                      | 32'(start_com_r) << START_COM_LSB;
  wire [31:0] status_w = 32'(commit_r) << STAT_BUSY
                       | 32'(ALTERNATION_SIGNAL_O) << STAT_ALT
                       | 32'(pin_r.master) << STAT_MASTER
                       | 32'(col_r) << STAT_COL_LSB
                       | 32'(page_r) << STAT_PAGE_LSB
                       | 32'(line_r) << STAT_LINE_LSB;
  wire [31:0] rd_mux = (AVS_ADDRESS_I == OFS_CTRL) ? ctrl_w :
                       (AVS_ADDRESS_I == OFS_START) ? start_w :
                       (AVS_ADDRESS_I == OFS_DUTY) ? 32'(duty_r) :
                       (AVS_ADDRESS_I == OFS_STATUS) ? status_w : 32'h0000_0000;
  wire [31:0] ctrl_m = be_merge(ctrl_w, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire [31:0] start_m = be_merge(start_w, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire [31:0] duty_m = be_merge(32'(duty_r), AVS_WRITEDATA_I,
                                AVS_BYTEENABLE_I);
  assign AVS_WAITREQUEST_O = req && !resp_r;
  assign AVS_READDATA_O = rdata_r;

  // avalon answer timing and read data
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      resp_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      resp_r <= req && !resp_r;
      if (req && !resp_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // display setting registers
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      ctrl_r <= CTRL_RST;
      start_line_r <= START_RST;
      start_com_r <= START_RST;
      duty_r <= DUTY_RST;
    end else if (wr_go) begin
      if (AVS_ADDRESS_I == OFS_CTRL) begin
        ctrl_r <= ctrl_m[CTRL_W-1:0];
      end
      if (AVS_ADDRESS_I == OFS_START) begin
        start_line_r <= start_m[START_LINE_LSB +: 7];
        start_com_r <= start_m[START_COM_LSB +: 7];
      end
      if (AVS_ADDRESS_I == OFS_DUTY) begin
        duty_r <= duty_m[3:0];
      end
    end
  end

  // duty, oscillator divider and display clock source
  wire [3:0] dcode = (duty_r == 4'h0 || duty_r > DUTY_MAX) ? DUTY_MAX
                                                            : duty_r;
  wire [6:0] lines = 7'({dcode, 3'b000});
  wire [31:0] div_max = 32'(CLK_HZ / FCL_HZ[int'(dcode) - 1]);
  wire master = pin_r.master;
  wire int_osc = master && pin_r.osc_sel;
  wire tick_int = (div_r >= div_max - 32'h0000_0001);
  wire tick_ext = pin_r.dot && !pin_q_r.dot;
  wire disp_tick = int_osc ? tick_int : tick_ext;
  wire slave_sync = !master && (pin_r.alt != pin_q_r.alt);
  wire frame_end = (line_r >= lines - 7'h01);
  wire alt_use = master ? alt_r : pin_r.alt;
  wire disp_on = ctrl_r[CTRL_ON] && (master || pin_r.dof_b);
  wire [6:0] fill_line = wrap80(start_line_r, line_r);
  wire [6:0] row_off = wrap80(start_com_r, line_r);
  wire [6:0] row_pos = ctrl_r[CTRL_SCAN_INV] ? 7'(LINES - 1) - row_off
                                              : row_off;
  wire [7:0] fill_byte = ram[ram_idx(4'(fill_line >> 3), fcol_r)];

  // oscillator divider, runs only with the internal source
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I || !int_osc || tick_int) begin
      div_r <= 32'h0000_0000;
    end else begin
      div_r <= div_r + 32'h0000_0001;
    end
  end

  // line counter and alternation per frame
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      line_r <= 7'h00;
      alt_r <= 1'b0;
      shown_row_r <= 7'h00;
      latch_r <= '0;
      dot_out_r <= 1'b0;
    end else begin
      dot_out_r <= (div_r < (div_max >> 1));
      if (slave_sync) begin
        line_r <= 7'h00;
      end else if (disp_tick) begin
        latch_r <= fill_buf_r;
        shown_row_r <= row_pos;
        line_r <= frame_end ? 7'h00 : line_r + 7'h01;
        if (frame_end) begin
          alt_r <= !alt_r;
        end
      end
    end
  end

  // line fetch: one column per cycle into the next line buffer
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      fill_r <= FILL_RUN;
      fcol_r <= 8'h00;
      fill_buf_r <= '0;
    end else begin
      case (fill_r)
        FILL_IDLE: begin
          if (disp_tick || slave_sync) begin
            fill_r <= FILL_RUN;
            fcol_r <= 8'h00;
          end
        end
        FILL_RUN: begin
          fill_buf_r[fcol_r] <= fill_byte[fill_line[2:0]];
          fcol_r <= fcol_r + 8'h01;
          if (fcol_r == COL_LAST) begin
            fill_r <= FILL_IDLE;
          end
        end
        default: begin
          fill_r <= FILL_IDLE;
        end
      endcase
    end
  end

  // drive level selection for rows and columns
  always_comb begin
    logic d;
    logic scan;
    int c;
    d = 1'b0;
    scan = 1'b0;
    c = 0;
    for (int r = 0; r < LINES; r++) begin
      scan = disp_on && (7'(r) == shown_row_r);
      if (ctrl_r[CTRL_PWR_SAVE]) begin
        row_nxt[r] = LVL_GND;
      end else if (scan) begin
        row_nxt[r] = alt_use ? LVL_GND : LVL_V1;
      end else begin
        row_nxt[r] = alt_use ? LVL_V2 : LVL_V5;
      end
    end
    for (int s = 0; s < COLS; s++) begin
      c = ctrl_r[CTRL_SWAP] ? (COLS - 1 - s) : s;
      d = disp_on && (latch_r[c] ^ ctrl_r[CTRL_INVERT]);
      if (ctrl_r[CTRL_PWR_SAVE]) begin
        colo_nxt[s] = LVL_GND;
      end else if (d) begin
        colo_nxt[s] = alt_use ? LVL_V1 : LVL_GND;
      end else begin
        colo_nxt[s] = alt_use ? LVL_V3 : LVL_V4;
      end
    end
  end

  // registered drive outputs, ground during reset
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      row_r <= '{default: LVL_GND};
      colo_r <= '{default: LVL_GND};
    end else begin
      row_r <= row_nxt;
      colo_r <= colo_nxt;
    end
  end
  assign ROW_DRIVE_OUTPUTS_O = row_r;
  assign COLUMN_DRIVE_OUTPUTS_O = colo_r;

  // timing pin directions by master/slave and oscillator select
  assign DOT_TIMING_PIN_O = dot_out_r;
  assign DOT_TIMING_PIN_OE_O = int_osc;
  assign ALTERNATION_SIGNAL_O = alt_r;
  assign ALTERNATION_SIGNAL_OE_O = master;
  assign DISPLAY_OFF_SYNC_B_O = ctrl_r[CTRL_ON];
  assign DISPLAY_OFF_SYNC_B_OE_O = master;

endmodule

/* File: lcd_pkg.sv */
// shared constants and types for the lcd host port and display timing
package lcd_pkg;
  // display ram geometry
  localparam int PAGES = 10;
  localparam int COLS = 132;
  localparam int LINES = 80;
  localparam int RAM_WORDS = PAGES * COLS;
  localparam logic [7:0] COL_LAST = 8'h83;
  localparam logic [3:0] PAGE_LAST = 4'h9;
  // system clock rate, default of the top parameter
  localparam int CLK_HZ_DEF = 100_000_000;
  // display clock in hz per duty code 1..10 (8..80 lines)
  localparam int FCL_HZ [10] = '{640, 1280, 1970, 2560, 3200, 3660, 4270,
                                 5120, 5120, 6400};
  // avalon register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_START = 4'h4;
  localparam logic [3:0] OFS_DUTY = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  // control register fields
  localparam int CTRL_ON = 0;
  localparam int CTRL_INVERT = 1;
  localparam int CTRL_SWAP = 2;
  localparam int CTRL_SCAN_INV = 3;
  localparam int CTRL_PWR_SAVE = 4;
  localparam int CTRL_W = 5;
  // start register fields
  localparam int START_LINE_LSB = 0;
  localparam int START_COM_LSB = 8;
  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ALT = 1;
  localparam int STAT_MASTER = 2;
  localparam int STAT_COL_LSB = 8;
  localparam int STAT_PAGE_LSB = 16;
  localparam int STAT_LINE_LSB = 20;
  // reset values and largest duty code
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [6:0] START_RST = 7'h00;
  localparam logic [3:0] DUTY_RST = 4'hA;
  localparam logic [3:0] DUTY_MAX = 4'hA;
  // host command opcodes in the upper nibble of a command byte
  localparam logic [3:0] OP_PAGE = 4'h2;
  localparam logic [3:0] OP_COL_HI = 4'h3;
  localparam logic [3:0] OP_COL_LO = 4'h4;
  // busy flag position in the status byte
  localparam int BUSY_BIT = 7;
  // drive level selected for a row or column output
  typedef enum logic [2:0] {LVL_GND, LVL_V1, LVL_V2, LVL_V3, LVL_V4,
                            LVL_V5} lvl_e;
  // external pins after sampling
  typedef struct packed {
    logic par_sel;
    logic bus_style;
    logic cs_low_b;
    logic cs_high;
    logic dc;
    logic rd_e;
    logic wr_rw;
    logic [7:0] data;
    logic master;
    logic osc_sel;
    logic dot;
    logic alt;
    logic dof_b;
  } pins_s;
  // pin idle pattern: deselected, strobes released
  localparam pins_s PIN_IDLE = '{cs_low_b: 1'b1, rd_e: 1'b1, wr_rw: 1'b1,
                                 dof_b: 1'b1, default: '0};
endpackage

/* File: mcu_model.sv */
// host microcontroller model driving the lcd bus pins
`timescale 1ns/1ps
module mcu_model
  import lcd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bus and pins
  input wire logic [7:0] bus_i,
  output pins_s pins_o
);
  logic drv;
  // start parallel, selected, strobes released
  initial begin
    drv = 1'b0;
    pins_o = PIN_IDLE;
    pins_o.par_sel = 1'b1;
    pins_o.cs_low_b = 1'b0;
    pins_o.cs_high = 1'b1;
  end
  // released lines toggle
  always @(posedge clk_i) begin
    if (!pins_o.par_sel)
      pins_o.data[5:0] <= ~pins_o.data[5:0];
    else if (!drv && rst_b_i)
      pins_o.data <= ~pins_o.data;
  end
  // port kind and bus style
  task automatic setup(input logic par, input logic sty);
    drv = 1'b1;
    @(posedge clk_i);
    pins_o.par_sel <= par;
    pins_o.bus_style <= sty;
    pins_o.rd_e <= !sty;
    pins_o.wr_rw <= 1'b1;
    pins_o.data[7:6] <= 2'b00;
    drv <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  // chip selects, then settle
  task automatic chip(input logic low_b, input logic high);
    @(posedge clk_i);
    pins_o.cs_low_b <= low_b;
    pins_o.cs_high <= high;
    repeat (12) @(posedge clk_i);
  endtask
  // one 10-cycle strobe, 10 idle
  task automatic xfer(input logic dc, input logic rd, input logic [7:0] b,
                      output logic [7:0] q);
    drv = !rd;
    @(posedge clk_i);
    pins_o.dc <= dc;
    if (!rd)
      pins_o.data <= b;
    pins_o.wr_rw <= rd;
    pins_o.rd_e <= pins_o.bus_style || !rd;
    repeat (10) @(posedge clk_i);
    q = bus_i;
    pins_o.rd_e <= !pins_o.bus_style;
    pins_o.wr_rw <= 1'b1;
    drv <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  // serial bits msb first, 8 cycles per clock phase
  task automatic ser(input logic dc, input logic [7:0] b, input int nbits);
    for (int i = 7; i > 7 - nbits; i--) begin
      @(posedge clk_i);
      pins_o.dc <= dc;
      pins_o.data[7] <= b[i];
      repeat (8) @(posedge clk_i);
      pins_o.data[6] <= 1'b1;
      repeat (8) @(posedge clk_i);
      pins_o.data[6] <= 1'b0;
      pins_o.data[7] <= ~b[i];
    end
    repeat (8) @(posedge clk_i);
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the lcd host port
`timescale 1ns/1ps
module testbench
  import lcd_pkg::*;
;
  localparam int TB_HZ = 2_000_000;
  localparam int FRAME = LINES * (TB_HZ / FCL_HZ[9]);
  localparam logic [31:0] NIL = 32'h0000_0000;
  logic clk, rst_b, rd, wr, waitreq;
  logic [3:0] addr, be;
  logic [31:0] wd, rdata;
  logic [7:0] dout, doe, bus;
  logic dot_o, dot_oe, alt_o, alt_oe, dof_o, dof_oe;
  lvl_e [LINES-1:0] rows;
  lvl_e [COLS-1:0] cols;
  pins_s pins;
  int errors, check_count;
  // resolved data bus seen by both sides
  assign bus = (doe & dout) | (~doe & pins.data);
  mcu_model mcu_model_inst (.clk_i(clk), .rst_b_i(rst_b), .bus_i(bus),
    .pins_o(pins));
  lcd_host_port #(.CLK_HZ(TB_HZ)) lcd_host_port_inst (.CLK_I(clk),
    .RST_B_I(rst_b), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be), .AVS_WRITEDATA_I(wd),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .PAR_SERIAL_SELECT_I(pins.par_sel), .BUS_STYLE_SELECT_I(pins.bus_style),
    .CHIP_SELECT_LOW_B_I(pins.cs_low_b), .CHIP_SELECT_HIGH_I(pins.cs_high),
    .DATA_COMMAND_SELECT_I(pins.dc), .RD_E_I(pins.rd_e),
    .WR_RW_I(pins.wr_rw), .DATA_I(bus), .DATA_O(dout), .DATA_OE_O(doe),
    .MASTER_SELECT_I(pins.master), .INTERNAL_OSC_SELECT_I(pins.osc_sel),
    .DOT_TIMING_PIN_I(dot_oe ? dot_o : pins.dot), .DOT_TIMING_PIN_O(dot_o),
    .DOT_TIMING_PIN_OE_O(dot_oe), .ALTERNATION_SIGNAL_O(alt_o),
    .ALTERNATION_SIGNAL_I(alt_oe ? alt_o : pins.alt),
    .ALTERNATION_SIGNAL_OE_O(alt_oe), .DISPLAY_OFF_SYNC_B_O(dof_o),
    .DISPLAY_OFF_SYNC_B_I(dof_oe ? dof_o : pins.dof_b),
    .DISPLAY_OFF_SYNC_B_OE_O(dof_oe), .ROW_DRIVE_OUTPUTS_O(rows),
    .COLUMN_DRIVE_OUTPUTS_O(cols));
  // verdict and end of run
  task automatic wrap_up();
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one avalon access
  task automatic av(input logic w, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (waitreq === 1'b0)
        break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic chkst(input logic [3:0] pg, input logic [7:0] col);
    logic [31:0] q;
    av(1'b0, OFS_STATUS, NIL, q);
    check("page", {28'h0, q[19:16]}, {28'h0, pg});
    check("column", {24'h0, q[15:8]}, {24'h0, col});
  endtask
  task automatic hw(input logic dc, input logic [7:0] b);
    logic [7:0] q;
    mcu_model_inst.xfer(dc, 1'b0, b, q);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    av(1'b0, OFS_CTRL, NIL, q);
    check("ctrl reset", q, {27'h0, CTRL_RST});
    av(1'b0, OFS_DUTY, NIL, q);
    check("duty reset", q, {28'h0, DUTY_RST});
    av(1'b0, 4'h2, NIL, q);
    check("unmapped", q, NIL);
    be <= 4'h1;
    av(1'b1, OFS_START, 32'h0000_0A05, q);
    be <= 4'hF;
    av(1'b0, OFS_START, NIL, q);
    check("start lanes", q, 32'h0000_0005);
    av(1'b1, OFS_START, NIL, q);
  endtask
  // parallel writes and pipelined reads
  task automatic t_par();
    logic [7:0] q;
    hw(1'b0, 8'h22);
    hw(1'b0, 8'h30);
    hw(1'b0, 8'h40);
    hw(1'b1, 8'hA5);
    hw(1'b1, 8'h5A);
    chkst(4'h2, 8'h02);
    mcu_model_inst.setup(1'b1, 1'b1);
    hw(1'b0, 8'h30);
    hw(1'b0, 8'h40);
    for (int i = 0; i < 3; i++) begin
      mcu_model_inst.xfer(1'b1, 1'b1, 8'h00, q);
      if (i > 0)
        check("ram read", {24'h0, q}, i == 1 ? 32'hA5 : 32'h5A);
    end
    mcu_model_inst.xfer(1'b0, 1'b1, 8'h00, q);
    check("busy", {31'h0, q[BUSY_BIT]}, NIL);
    chkst(4'h2, 8'h03);
    hw(1'b0, 8'h38);
    hw(1'b0, 8'h42);
    hw(1'b1, 8'h11);
    hw(1'b1, 8'h22);
    hw(1'b0, 8'h2A);
    chkst(4'h2, 8'h83);
  endtask
  // deselected accesses ignored
  task automatic t_desel();
    logic [7:0] q;
    for (int k = 0; k < 2; k++) begin
      mcu_model_inst.chip(k[0], k[0]);
      hw(1'b0, 8'h25);
      mcu_model_inst.xfer(1'b1, 1'b1, 8'h00, q);
      mcu_model_inst.chip(1'b0, 1'b1);
    end
    chkst(4'h2, 8'h83);
  endtask
  task automatic t_serial();
    mcu_model_inst.setup(1'b0, 1'b0);
    mcu_model_inst.ser(1'b0, 8'h21, 8);
    chkst(4'h1, 8'h83);
    mcu_model_inst.ser(1'b0, 8'h24, 4);
    mcu_model_inst.chip(1'b1, 1'b1);
    mcu_model_inst.chip(1'b0, 1'b1);
    mcu_model_inst.ser(1'b0, 8'h23, 8);
    chkst(4'h3, 8'h83);
    mcu_model_inst.ser(1'b0, 8'h30, 8);
    mcu_model_inst.ser(1'b0, 8'h40, 8);
    mcu_model_inst.ser(1'b1, 8'hC3, 8);
    chkst(4'h3, 8'h01);
    mcu_model_inst.setup(1'b1, 1'b0);
  endtask
  // timing pins, alternation, power save
  task automatic t_timing();
    logic [31:0] q;
    logic a;
    int n;
    @(posedge clk);
    mcu_model_inst.pins_o.master <= 1'b1;
    mcu_model_inst.pins_o.osc_sel <= 1'b1;
    av(1'b1, OFS_CTRL, 32'h0000_0001, q);
    repeat (20) @(posedge clk);
    check("oe", {29'h0, dot_oe, alt_oe, dof_oe}, 32'h0000_0007);
    check("dof", {31'h0, dof_o}, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      a = alt_o;
      for (n = 0; n < 2 * FRAME && alt_o === a; n++)
        @(posedge clk);
      if (n == 2 * FRAME) begin
        errors++;
        wrap_up();
      end
    end
    check("frame", {31'h0, n > FRAME - 100 && n < FRAME + 100}, 1);
    av(1'b1, OFS_CTRL, 32'h0000_0011, q);
    repeat (400) @(posedge clk);
    check("rows", {31'h0, rows === '0}, 32'h0000_0001);
    check("cols", {31'h0, cols === '0}, 32'h0000_0001);
    mcu_model_inst.pins_o.osc_sel <= 1'b0;
    repeat (20) @(posedge clk);
    check("osc off", {30'h0, dot_oe, alt_oe}, 32'h0000_0001);
    mcu_model_inst.pins_o.master <= 1'b0;
    repeat (20) @(posedge clk);
    check("slave", {29'h0, dot_oe, alt_oe, dof_oe}, NIL);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // reset, then scenarios in order
  initial begin
    rst_b = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 4'h0;
    be = 4'hF;
    wd = NIL;
    errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    t_regs();
    t_par();
    t_desel();
    t_serial();
    t_timing();
    wrap_up();
  end
endmodule
bind lcd_host_port lcd_chk lcd_chk_inst (.*);
